/* File: src/dtx_cfg.svh */
`ifndef DTX_CFG_SVH
`define DTX_CFG_SVH
// Short direct window and table-call window
`define DTX_SADDR_LO 16'hFE20
`define DTX_SADDR_HI 16'hFF1F
`define DTX_TBL_LO 16'h0040
`define DTX_TBL_HI 16'h007F
// General register numbers
`define DTX_REG_X 3'h0
`define DTX_REG_A 3'h1
`define DTX_REG_L 3'h6
`define DTX_REG_H 3'h7
// Register pair numbers
`define DTX_PAIR0 2'h0
`define DTX_PAIR2 2'h2
`define DTX_PAIR3 2'h3
// Status word layout and reset value
`define DTX_BIT_ZERO 6
`define DTX_BIT_AUX 4
`define DTX_BIT_CARRY 0
`define DTX_STAT_RST 8'h00
// Instruction clocks and lengths
`define DTX_CLK4 4'h4
`define DTX_CLK6 4'h6
`define DTX_CLK8 4'h8
`define DTX_LEN1 2'h1
`define DTX_LEN2 2'h2
`define DTX_LEN3 2'h3
// Schedule points, counted in CPU clocks from acceptance
`define DTX_CNT_FIRST 4'h1
`define DTX_CNT_LO 4'h2
`define DTX_CNT_HI 4'h3
`endif

/* File: src/dtx_pkg.sv */
package dtx_pkg;
  typedef enum logic [4:0] {
    OP_MV_R_IMM = 5'b00000, OP_MV_SA_IMM = 5'b00001, OP_MV_SFR_IMM = 5'b00010,
    OP_MV_A_R = 5'b00011, OP_MV_R_A = 5'b00100, OP_MV_A_SA = 5'b00101,
    OP_MV_SA_A = 5'b00110, OP_MV_A_SFR = 5'b00111, OP_MV_SFR_A = 5'b01000,
    OP_MV_A_ABS = 5'b01001, OP_MV_ABS_A = 5'b01010, OP_MV_ST_IMM = 5'b01011,
    OP_MV_A_ST = 5'b01100, OP_MV_ST_A = 5'b01101, OP_MV_A_IND = 5'b01110,
    OP_MV_IND_A = 5'b01111, OP_MV_A_IDX = 5'b10000, OP_MV_IDX_A = 5'b10001,
    OP_BX_X = 5'b10010, OP_BX_R = 5'b10011, OP_BX_SA = 5'b10100,
    OP_BX_SFR = 5'b10101, OP_BX_IND = 5'b10110, OP_BX_IDX = 5'b10111,
    OP_WM_RP_IMM = 5'b11000, OP_WM_P0_SA = 5'b11001, OP_WM_SA_P0 = 5'b11010,
    OP_WM_P0_RP = 5'b11011, OP_WM_RP_P0 = 5'b11100, OP_WX_P0_RP = 5'b11101
  } dtx_op_e;

  typedef enum logic [2:0] {
    FA_KEEP = 3'b000, FA_CLEAR = 3'b001, FA_SET = 3'b010,
    FA_RESULT = 3'b011, FA_RESTORE = 3'b100
  } dtx_flag_act_e;

  typedef enum logic {
    ST_IDLE = 1'b0,
    ST_RUN = 1'b1
  } dtx_state_e;

  typedef struct packed {
    dtx_op_e op;
    logic [2:0] gr;
    logic [1:0] rp;
    logic [15:0] addr;
    logic [15:0] imm;
  } dtx_instr_s;

  typedef struct packed {
    logic req;
    logic we;
    logic sfr;
    logic [15:0] addr;
    logic [7:0] wdata;
  } dtx_bus_s;

  typedef struct packed {
    logic [3:0] clocks;
    logic [1:0] bytes;
  } dtx_cost_s;
endpackage : dtx_pkg

/* File: src/dtx_exec.sv */
`timescale 1ns/100ps
`default_nettype none
`include "dtx_cfg.svh"
module dtx_exec import dtx_pkg::*; (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic cpu_clk_en_i,
  input wire logic instr_valid_i,
  input wire dtx_instr_s instr_i,
  input wire logic [7:0] mem_rdata_i,
  input wire logic [7:0] saved_status_i,
  input wire logic [15:0] pc_i,
  input wire logic [7:0] disp_i,
  input wire logic [15:0] tbl_addr_i,
  output logic busy_o,
  output logic done_o,
  output logic illegal_o,
  output logic [1:0] instr_len_o,
  output dtx_bus_s bus_o,
  output logic [63:0] gpr_o,
  output logic [7:0] status_o,
  output logic [15:0] branch_target_o,
  output logic tbl_ok_o
);
  ////////////////////////////////////////////////////////////////////////////
  dtx_state_e state_r;
  dtx_instr_s ins_r;
  dtx_cost_s cost_acc;
  logic [3:0] cnt_r;
  logic [15:0] addr_r;
  logic [15:0] addr_acc;
  logic [7:0] dlo_r;
  logic [7:0] dhi_r;
  logic [7:0][7:0] gpr_r;
  logic [7:0] wen;
  logic [7:0][7:0] wval;
  logic [7:0] stat_r;
  logic [7:0] stat_nxt;
  logic accept;
  logic finish;
  logic legal_acc;
  dtx_flag_act_e fact;

  // Pair p is {register 2p+1, register 2p}; the high byte is the odd register
  function automatic logic [15:0] pair_of(input logic [7:0][7:0] g, input logic [1:0] p);
    pair_of = {g[{p, 1'b1}], g[{p, 1'b0}]};
  endfunction : pair_of

  function automatic logic in_saddr(input logic [15:0] a);
    in_saddr = (a >= `DTX_SADDR_LO) && (a <= `DTX_SADDR_HI);
  endfunction : in_saddr

  // Cost per operation, in CPU clocks and encoding bytes
  function automatic dtx_cost_s cost_of(input dtx_op_e op);
    case (op)
      OP_MV_R_IMM, OP_MV_SA_IMM, OP_MV_SFR_IMM, OP_MV_ST_IMM,
      OP_WM_RP_IMM: cost_of = '{`DTX_CLK6, `DTX_LEN3};
      OP_MV_A_R, OP_MV_R_A, OP_MV_A_SA, OP_MV_SA_A, OP_MV_A_SFR, OP_MV_SFR_A,
      OP_MV_A_ST, OP_MV_ST_A: cost_of = '{`DTX_CLK4, `DTX_LEN2};
      OP_MV_A_ABS, OP_MV_ABS_A: cost_of = '{`DTX_CLK8, `DTX_LEN3};
      OP_MV_A_IND, OP_MV_IND_A: cost_of = '{`DTX_CLK6, `DTX_LEN1};
      OP_MV_A_IDX, OP_MV_IDX_A: cost_of = '{`DTX_CLK6, `DTX_LEN2};
      OP_BX_X: cost_of = '{`DTX_CLK4, `DTX_LEN1};
      OP_BX_R, OP_BX_SA, OP_BX_SFR: cost_of = '{`DTX_CLK6, `DTX_LEN2};
      OP_BX_IND: cost_of = '{`DTX_CLK8, `DTX_LEN1};
      OP_BX_IDX: cost_of = '{`DTX_CLK8, `DTX_LEN2};
      OP_WM_P0_SA: cost_of = '{`DTX_CLK6, `DTX_LEN2};
      OP_WM_SA_P0: cost_of = '{`DTX_CLK8, `DTX_LEN2};
      OP_WM_P0_RP, OP_WM_RP_P0: cost_of = '{`DTX_CLK4, `DTX_LEN1};
      OP_WX_P0_RP: cost_of = '{`DTX_CLK8, `DTX_LEN1};
      default: cost_of = '{`DTX_CLK4, `DTX_LEN1};
    endcase
  endfunction : cost_of

  // Operand legality; absolute byte forms take any 16-bit address
  function automatic logic legal_of(input dtx_instr_s i);
    case (i.op)
      OP_MV_SA_IMM, OP_MV_A_SA, OP_MV_SA_A, OP_BX_SA: legal_of = in_saddr(i.addr);
      OP_WM_P0_SA, OP_WM_SA_P0: legal_of = in_saddr(i.addr) && !i.addr[0];
      OP_MV_A_R, OP_MV_R_A: legal_of = (i.gr != `DTX_REG_A);
      OP_BX_R: legal_of = (i.gr != `DTX_REG_A) && (i.gr != `DTX_REG_X);
      OP_MV_A_IND, OP_MV_IND_A, OP_BX_IND: legal_of = (i.rp == `DTX_PAIR2) || (i.rp == `DTX_PAIR3);
      OP_WM_P0_RP, OP_WM_RP_P0, OP_WX_P0_RP: legal_of = (i.rp != `DTX_PAIR0);
      default: legal_of = 1'b1;
    endcase
  endfunction : legal_of

  // One flag under one of the five handling kinds
  function automatic logic flag_apply(input dtx_flag_act_e a, input logic cur, input logic res,
                                      input logic sav);
    case (a)
      FA_CLEAR: flag_apply = 1'b0;
      FA_SET: flag_apply = 1'b1;
      FA_RESULT: flag_apply = res;
      FA_RESTORE: flag_apply = sav;
      default: flag_apply = cur;
    endcase
  endfunction : flag_apply

  ////////////////////////////////////////////////////////////////////////////
  // Acceptance and operand address; indexed form adds the offset to pair 3
  always_comb begin
    cost_acc = cost_of(instr_i.op);
    legal_acc = legal_of(instr_i);
    case (instr_i.op)
      OP_MV_A_IND, OP_MV_IND_A, OP_BX_IND: addr_acc = pair_of(gpr_r, instr_i.rp);
      OP_MV_A_IDX, OP_MV_IDX_A, OP_BX_IDX: addr_acc = pair_of(gpr_r, `DTX_PAIR3) + {8'h00, instr_i.imm[7:0]};
      default: addr_acc = instr_i.addr;
    endcase
  end

  assign accept = cpu_clk_en_i && instr_valid_i && (state_r == ST_IDLE) && legal_acc;
  // Counting only on the enable makes every count a CPU clock, not a system clock
  assign finish = cpu_clk_en_i && (state_r == ST_RUN) && (cnt_r == ins_cost_last());

  // Member select on a call result is not taken everywhere, so go through a local
  function automatic logic [3:0] ins_cost_last();
    dtx_cost_s c;
    c = cost_of(ins_r.op);
    ins_cost_last = c.clocks - `DTX_CNT_FIRST;
  endfunction : ins_cost_last

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer: accept edge is clock 1, finish edge is the last clock
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      state_r <= ST_IDLE;
      cnt_r <= 4'h0;
      ins_r <= '0;
      addr_r <= 16'h0000;
      instr_len_o <= 2'h0;
    end else if (accept) begin
      state_r <= ST_RUN;
      cnt_r <= `DTX_CNT_FIRST;
      ins_r <= instr_i;
      addr_r <= addr_acc;
      instr_len_o <= cost_acc.bytes;
    end else if (finish) begin
      state_r <= ST_IDLE;
    end else if (cpu_clk_en_i && (state_r == ST_RUN)) begin
      cnt_r <= cnt_r + 4'h1;
    end
  end

  // Done and refusal pulses last one system clock; busy_o stays high from accept to finish
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      busy_o <= 1'b0;
      done_o <= 1'b0;
      illegal_o <= 1'b0;
    end else begin
      busy_o <= accept || (busy_o && !finish);
      done_o <= finish;
      illegal_o <= cpu_clk_en_i && instr_valid_i && (state_r == ST_IDLE) && !legal_acc;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Memory and SFR bus; a request stands one CPU clock and data is captured
  // on the second enable after it is raised, so memory has two CPU clocks to answer
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      bus_o <= '0;
    end else if (accept) begin
      bus_o <= '0;
      case (instr_i.op)
        OP_MV_A_SA, OP_MV_A_SFR, OP_MV_A_ABS, OP_MV_A_IND, OP_MV_A_IDX, OP_BX_SA, OP_BX_SFR,
        OP_BX_IND, OP_BX_IDX, OP_WM_P0_SA: bus_o <= '{1'b1, 1'b0, instr_i.op inside {OP_MV_A_SFR, OP_BX_SFR},
                                                       addr_acc, 8'h00};
        default: bus_o <= '0;
      endcase
    end else if (finish) begin
      bus_o <= '0;
    end else if (cpu_clk_en_i && (state_r == ST_RUN)) begin
      bus_o <= '0;
      case (ins_r.op)
        OP_WM_P0_SA: if (cnt_r == `DTX_CNT_FIRST) bus_o <= '{1'b1, 1'b0, 1'b0, addr_r | 16'h0001, 8'h00};
        OP_WM_SA_P0: begin
          if (cnt_r == ins_cost_last() - 4'h2) bus_o <= '{1'b1, 1'b1, 1'b0, addr_r, gpr_r[`DTX_REG_X]};
          if (cnt_r == ins_cost_last() - 4'h1) bus_o <= '{1'b1, 1'b1, 1'b0, addr_r | 16'h0001,
                                                           gpr_r[`DTX_REG_A]};
        end
        OP_MV_SA_IMM, OP_MV_SFR_IMM: if (cnt_r == ins_cost_last() - 4'h1)
          bus_o <= '{1'b1, 1'b1, ins_r.op == OP_MV_SFR_IMM, addr_r, ins_r.imm[7:0]};
        OP_MV_SA_A, OP_MV_SFR_A, OP_MV_ABS_A, OP_MV_IND_A, OP_MV_IDX_A, OP_BX_SA, OP_BX_SFR, OP_BX_IND,
        OP_BX_IDX: if (cnt_r == ins_cost_last() - 4'h1)
          bus_o <= '{1'b1, 1'b1, ins_r.op inside {OP_MV_SFR_A, OP_BX_SFR}, addr_r, gpr_r[`DTX_REG_A]};
        default: bus_o <= '0;
      endcase
    end
  end

  // Read data capture
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      dlo_r <= 8'h00;
      dhi_r <= 8'h00;
    end else if (cpu_clk_en_i && (state_r == ST_RUN)) begin
      if (cnt_r == `DTX_CNT_LO) dlo_r <= mem_rdata_i;
      if (cnt_r == `DTX_CNT_HI) dhi_r <= mem_rdata_i;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register write-back at the finish edge
  always_comb begin
    wen = 8'h00;
    wval = '0;
    case (ins_r.op)
      OP_MV_R_IMM: begin wen[ins_r.gr] = 1'b1; wval[ins_r.gr] = ins_r.imm[7:0]; end
      OP_MV_A_R: begin wen[`DTX_REG_A] = 1'b1; wval[`DTX_REG_A] = gpr_r[ins_r.gr]; end
      OP_MV_R_A: begin wen[ins_r.gr] = 1'b1; wval[ins_r.gr] = gpr_r[`DTX_REG_A]; end
      OP_MV_A_SA, OP_MV_A_SFR, OP_MV_A_ABS, OP_MV_A_IND, OP_MV_A_IDX, OP_BX_SA, OP_BX_SFR, OP_BX_IND,
      OP_BX_IDX: begin wen[`DTX_REG_A] = 1'b1; wval[`DTX_REG_A] = dlo_r; end
      OP_MV_A_ST: begin wen[`DTX_REG_A] = 1'b1; wval[`DTX_REG_A] = stat_r; end
      OP_BX_X, OP_BX_R: begin
        wen[`DTX_REG_A] = 1'b1;
        wval[`DTX_REG_A] = (ins_r.op == OP_BX_X) ? gpr_r[`DTX_REG_X] : gpr_r[ins_r.gr];
        wen[(ins_r.op == OP_BX_X) ? `DTX_REG_X : ins_r.gr] = 1'b1;
        wval[(ins_r.op == OP_BX_X) ? `DTX_REG_X : ins_r.gr] = gpr_r[`DTX_REG_A];
      end
      OP_WM_P0_SA: begin wen[1:0] = 2'b11; wval[1:0] = {dhi_r, dlo_r}; end
      OP_WM_RP_IMM, OP_WM_RP_P0: begin
        wen[{ins_r.rp, 1'b1}] = 1'b1;
        wen[{ins_r.rp, 1'b0}] = 1'b1;
        {wval[{ins_r.rp, 1'b1}], wval[{ins_r.rp, 1'b0}]} =
          (ins_r.op == OP_WM_RP_IMM) ? ins_r.imm : pair_of(gpr_r, `DTX_PAIR0);
      end
      OP_WM_P0_RP, OP_WX_P0_RP: begin
        wen[1:0] = 2'b11;
        wval[1:0] = pair_of(gpr_r, ins_r.rp);
        if (ins_r.op == OP_WX_P0_RP) begin
          wen[{ins_r.rp, 1'b1}] = 1'b1;
          wen[{ins_r.rp, 1'b0}] = 1'b1;
          {wval[{ins_r.rp, 1'b1}], wval[{ins_r.rp, 1'b0}]} = pair_of(gpr_r, `DTX_PAIR0);
        end
      end
      default: wen = 8'h00;
    endcase
  end

  // One flip-flop bank per general register
  for (genvar g = 0; g < 8; g++) begin : g_gpr
    always_ff @(posedge clk_i) begin
      if (!rst_n_i) gpr_r[g] <= 8'h00;
      else if (finish && wen[g]) gpr_r[g] <= wval[g];
    end
  end
  assign gpr_o = gpr_r;

  ////////////////////////////////////////////////////////////////////////////
  // Status word: only the three flag bits follow a write, the rest is kept
  always_comb begin
    fact = (ins_r.op inside {OP_MV_ST_IMM, OP_MV_ST_A}) ? FA_RESULT : FA_KEEP;
    stat_nxt = stat_r;
    for (int b = 0; b < 8; b++) begin
      if (b == `DTX_BIT_ZERO || b == `DTX_BIT_AUX || b == `DTX_BIT_CARRY)
        stat_nxt[b] = flag_apply(fact, stat_r[b],
                                 (ins_r.op == OP_MV_ST_IMM) ? ins_r.imm[b] : gpr_r[`DTX_REG_A][b],
                                 saved_status_i[b]);
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) stat_r <= `DTX_STAT_RST;
    else if (finish) stat_r <= stat_nxt;
  end
  assign status_o = stat_r;

  ////////////////////////////////////////////////////////////////////////////
  // Operand helpers: relative target and table-call check, registered each clock
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      branch_target_o <= 16'h0000;
      tbl_ok_o <= 1'b0;
    end else begin
      branch_target_o <= pc_i + {{8{disp_i[7]}}, disp_i};
      tbl_ok_o <= (tbl_addr_i >= `DTX_TBL_LO) && (tbl_addr_i <= `DTX_TBL_HI) && !tbl_addr_i[0];
    end
  end
endmodule : dtx_exec
`default_nettype wire

/* File: tb/dtx_exec_props.sv */
`timescale 1ns/100ps
`default_nettype none
module dtx_exec_props import dtx_pkg::*; (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic cpu_clk_en_i,
  input wire logic instr_valid_i,
  input wire dtx_instr_s instr_i,
  input wire logic [15:0] pc_i,
  input wire logic [7:0] disp_i,
  input wire logic [15:0] tbl_addr_i,
  input wire logic busy_o,
  input wire logic done_o,
  input wire logic illegal_o,
  input wire logic [63:0] gpr_o,
  input wire logic [7:0] status_o
  ,input wire logic [15:0] branch_target_o,
  input wire logic tbl_ok_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  ////////////////////////////////////////////////////////////////////////////////
  // Fresh offer from idle; a repeated offer is left out since idle timing is open there
  sequence s_offer;
    instr_valid_i && cpu_clk_en_i && !busy_o && !$past(instr_valid_i && cpu_clk_en_i);
  endsequence
  sequence s_refused;
    illegal_o ##1 !illegal_o;
  endsequence
  property p_ill_quiet; illegal_o |-> $stable(gpr_o) && $stable(status_o) && !busy_o; endproperty
  a_ill_quiet: assert property (p_ill_quiet) else $error("refused offer changed state");
  property p_sa_range;
    s_offer and (instr_i.op == OP_MV_A_SA && (instr_i.addr < 16'hfe20 || instr_i.addr > 16'hff1f)) |=> s_refused;
  endproperty
  a_sa_range: assert property (p_sa_range) else $error("short direct outside window taken");
  property p_tbl;
    1'b1 |=> tbl_ok_o == (!$past(tbl_addr_i[0]) && $past(tbl_addr_i) >= 16'h0040 && $past(tbl_addr_i) <= 16'h007f);
  endproperty
  a_tbl: assert property (p_tbl) else $error("table call check wrong");
  property p_branch; 1'b1 |=> branch_target_o == $past(pc_i) + {{8{$past(disp_i[7])}}, $past(disp_i)}; endproperty
  a_branch: assert property (p_branch) else $error("branch target wrong");
  property p_done_pulse; $rose(done_o) |-> !busy_o ##1 !done_o; endproperty
  a_done_pulse: assert property (p_done_pulse) else $error("done not a single pulse");
  property p_ill_pair;
    s_offer and ((instr_i.op == OP_WM_P0_RP || instr_i.op == OP_WM_RP_P0 || instr_i.op == OP_WX_P0_RP)
      && instr_i.rp == 2'h0) |=> s_refused;
  endproperty
  a_ill_pair: assert property (p_ill_pair) else $error("pair 0 operand taken");
  property p_ill_acc;
    s_offer and ((instr_i.op == OP_MV_A_R || instr_i.op == OP_MV_R_A) && instr_i.gr == 3'h1) |=> illegal_o;
  endproperty
  a_ill_acc: assert property (p_ill_acc) else $error("accumulator as register operand taken");
  property p_ill_bx; s_offer and (instr_i.op == OP_BX_R && instr_i.gr <= 3'h1) |=> illegal_o; endproperty
  a_ill_bx: assert property (p_ill_bx) else $error("exchange with register 0 or 1 taken");
  // Flags only move at the finish edge, so done_o must be high in the same cycle
  property p_stat_fin; $changed(status_o) |-> done_o; endproperty
  a_stat_fin: assert property (p_stat_fin) else $error("status changed outside finish");
endmodule : dtx_exec_props
bind dtx_exec dtx_exec_props i_props (.clk_i(clk_i), .rst_n_i(rst_n_i), .cpu_clk_en_i(cpu_clk_en_i),
  .instr_valid_i(instr_valid_i), .instr_i(instr_i), .pc_i(pc_i), .disp_i(disp_i), .tbl_addr_i(tbl_addr_i),
  .busy_o(busy_o), .done_o(done_o), .illegal_o(illegal_o), .gpr_o(gpr_o), .status_o(status_o),
  .branch_target_o(branch_target_o), .tbl_ok_o(tbl_ok_o));
`default_nettype wire

/* File: tb/tb_data_transfer_instr_exec.sv */
`timescale 1ns/100ps
`default_nettype none
module tb_data_transfer_instr_exec import dtx_pkg::*;;
  logic clk_i = 0, rst_n_i = 0, cpu_clk_en_i = 1, instr_valid_i = 0, slow = 0;
  dtx_instr_s instr_i = '0;
  logic [7:0] mem_rdata_i = 8'h00, disp_i = 8'hf0;
  logic [15:0] pc_i = 16'h1000, tbl_addr_i = 16'h0041;
  logic busy_o, done_o, illegal_o, tbl_ok_o;
  logic [1:0] instr_len_o;
  dtx_bus_s bus_o, wr_last, rd_last;
  logic [63:0] gpr_o;
  logic [7:0] status_o;
  logic [15:0] branch_target_o;
  int error_cnt = 0, checks_done = 0;
  dtx_exec i_dut (.clk_i(clk_i), .rst_n_i(rst_n_i), .cpu_clk_en_i(cpu_clk_en_i), .instr_valid_i(instr_valid_i),
    .instr_i(instr_i), .mem_rdata_i(mem_rdata_i), .saved_status_i(8'h00), .pc_i(pc_i), .disp_i(disp_i),
    .tbl_addr_i(tbl_addr_i), .busy_o(busy_o), .done_o(done_o), .illegal_o(illegal_o), .instr_len_o(instr_len_o),
    .bus_o(bus_o), .gpr_o(gpr_o), .status_o(status_o), .branch_target_o(branch_target_o), .tbl_ok_o(tbl_ok_o));
  ////////////////////////////////////////////////////////////////////////////////
  // 100 MHz clock
  initial begin
    forever #5 clk_i = ~clk_i;
  end
  // Enable toggles in slow mode so counts must follow enabled edges only
  always @(posedge clk_i) begin
    #1;
    cpu_clk_en_i = slow ? !cpu_clk_en_i : 1'b1;
  end
  // Keep the last write and read request seen on the bus
  always @(posedge clk_i) begin
    if (bus_o.req === 1'b1) begin
      if (bus_o.we) wr_last = bus_o;
      else rd_last = bus_o;
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [79:0] seen, input logic [79:0] exp);
    checks_done++;
    if (seen !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: got %h, want %h", $time, seen, exp);
    end
  endtask : chk
  // Offer one instruction, count enabled edges up to finish, compare length
  task automatic run(input dtx_instr_s ins, input logic [7:0] rd, input int clocks, input logic [1:0] len);
    int n;
    int t;
    logic e;
    @(posedge clk_i);
    #1;
    instr_i = ins;
    mem_rdata_i = rd;
    instr_valid_i = 1;
    do @(posedge clk_i); while (cpu_clk_en_i !== 1'b1);
    #1;
    instr_valid_i = 0;
    n = 1;
    for (t = 0; t < 40; t++) begin
      @(posedge clk_i);
      e = cpu_clk_en_i;
      #1;
      // The finish edge itself is an enabled edge and counts
      n += e;
      if (done_o === 1'b1) break;
    end
    chk(n, clocks);
    chk(instr_len_o, len);
  endtask : run
  // Offer an operand that must be refused with nothing changed
  task automatic ill(input dtx_instr_s ins);
    logic [63:0] g;
    g = gpr_o;
    @(posedge clk_i);
    #1;
    instr_i = ins;
    instr_valid_i = 1;
    @(posedge clk_i);
    #1;
    instr_valid_i = 0;
    chk(illegal_o, 1'b1);
    chk(busy_o, 1'b0);
    @(posedge clk_i);
    #1;
    chk(gpr_o, g);
  endtask : ill
  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_bytes;
    chk({gpr_o, status_o}, 72'h0);
    chk({branch_target_o, tbl_ok_o}, {16'h0ff0, 1'b0});
    run('{OP_MV_R_IMM, 3'h2, 2'h0, 16'h0000, 16'h005a}, 8'h00, 6, 2'h3);
    chk({gpr_o[23:16], status_o}, 16'h5a00);
    run('{OP_MV_A_R, 3'h2, 2'h0, 16'h0000, 16'h0000}, 8'h00, 4, 2'h2);
    chk(gpr_o[15:8], 8'h5a);
    run('{OP_MV_A_ABS, 3'h0, 2'h0, 16'h1234, 16'h0000}, 8'hc3, 8, 2'h3);
    chk({rd_last.addr, gpr_o[15:8]}, 24'h1234_c3);
    run('{OP_MV_SA_A, 3'h0, 2'h0, 16'hfe20, 16'h0000}, 8'h00, 4, 2'h2);
    chk({wr_last.addr, wr_last.wdata}, 24'hfe20_c3);
    run('{OP_MV_SFR_IMM, 3'h0, 2'h0, 16'hff10, 16'h00a5}, 8'h00, 6, 2'h3);
    chk({wr_last.sfr, wr_last.addr, wr_last.wdata}, {1'b1, 16'hff10, 8'ha5});
  endtask : t_bytes
  task automatic t_status;
    run('{OP_MV_ST_IMM, 3'h0, 2'h0, 16'h0000, 16'h00ff}, 8'h00, 6, 2'h3);
    chk(status_o, 8'h51);
    run('{OP_MV_A_ST, 3'h0, 2'h0, 16'h0000, 16'h0000}, 8'h00, 4, 2'h2);
    chk({gpr_o[15:8], status_o}, 16'h5151);
    run('{OP_MV_R_IMM, 3'h1, 2'h0, 16'h0000, 16'h0000}, 8'h00, 6, 2'h3);
    run('{OP_MV_ST_A, 3'h0, 2'h0, 16'h0000, 16'h0000}, 8'h00, 4, 2'h2);
    chk(status_o, 8'h00);
  endtask : t_status
  task automatic t_words;
    run('{OP_WM_RP_IMM, 3'h0, 2'h1, 16'h0000, 16'hbeef}, 8'h00, 6, 2'h3);
    chk(gpr_o[31:0], 32'hbeef_0000);
    run('{OP_WX_P0_RP, 3'h0, 2'h1, 16'h0000, 16'h0000}, 8'h00, 8, 2'h1);
    chk(gpr_o[31:0], 32'h0000_beef);
    run('{OP_WM_RP_IMM, 3'h0, 2'h2, 16'h0000, 16'hfe80}, 8'h00, 6, 2'h3);
    run('{OP_MV_A_IND, 3'h0, 2'h2, 16'h0000, 16'h0000}, 8'h77, 6, 2'h1);
    chk({rd_last.addr, gpr_o[15:8]}, 24'hfe80_77);
    run('{OP_BX_IND, 3'h0, 2'h2, 16'h0000, 16'h0000}, 8'h66, 8, 2'h1);
    chk({wr_last.addr, wr_last.wdata, gpr_o[15:8]}, 32'hfe80_7766);
    run('{OP_WM_SA_P0, 3'h0, 2'h0, 16'hfe22, 16'h0000}, 8'h00, 8, 2'h2);
    chk({wr_last.addr, wr_last.wdata}, 24'hfe23_66);
    run('{OP_WM_RP_P0, 3'h0, 2'h3, 16'h0000, 16'h0000}, 8'h00, 4, 2'h1);
    chk(gpr_o[63:48], 16'h66ef);
  endtask : t_words
  task automatic t_refuse;
    ill('{OP_MV_A_R, 3'h1, 2'h0, 16'h0000, 16'h0000});
    ill('{OP_BX_R, 3'h0, 2'h0, 16'h0000, 16'h0000});
    ill('{OP_BX_R, 3'h1, 2'h0, 16'h0000, 16'h0000});
    ill('{OP_WX_P0_RP, 3'h0, 2'h0, 16'h0000, 16'h0000});
    ill('{OP_MV_A_SA, 3'h0, 2'h0, 16'hfe1f, 16'h0000});
    ill('{OP_MV_A_SA, 3'h0, 2'h0, 16'hff20, 16'h0000});
    ill('{OP_WM_P0_SA, 3'h0, 2'h0, 16'hfe21, 16'h0000});
    tbl_addr_i = 16'h007e;
    @(posedge clk_i);
    #1;
    chk(tbl_ok_o, 1'b1);
  endtask : t_refuse
  // Half-rate CPU clock: instruction time stays four enabled edges
  task automatic t_slow;
    slow = 1;
    run('{OP_MV_A_R, 3'h2, 2'h0, 16'h0000, 16'h0000}, 8'h00, 4, 2'h2);
    chk(gpr_o[15:8], 8'h00);
    slow = 0;
  endtask : t_slow
  ////////////////////////////////////////////////////////////////////////////////
  task automatic stop_test;
    $display("checks %0d, errors %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : stop_test
  // Whole run needs well under 2000 cycles
  initial begin
    #(20000 * 10);
    error_cnt++;
    stop_test();
  end
  initial begin
    repeat (20) @(posedge clk_i);
    #1;
    rst_n_i = 1;
    @(posedge clk_i);
    #1;
    t_bytes();
    t_status();
    t_words();
    t_refuse();
    t_slow();
    stop_test();
  end
endmodule : tb_data_transfer_instr_exec
`default_nettype wire
